// file: dv/sbp_guard_chk.sv
// checker for the block guard top ports
// assumes a bind onto sbp_guard and a single clock domain
`timescale 1ns/10ps
`include "sbp_map.svh"
module sbp_guard_chk #(
  parameter int PROG_CYC = 20 // program time in clocks
) (
  input wire logic CLOCK, // system clock
  input wire logic RESET, // synchronous reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic ARRAY_RD, // array read probe
  input wire logic ARRAY_WR, // array write probe
  input wire logic ARRAY_RD_OK, // read accepted
  input wire logic ARRAY_WR_OK // write allowed
);
  localparam int PROG_LIM = PROG_CYC + 4; // slack for the done handshake
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // a guard program command that really started: a held read is already refused;
  // a frozen program fails without an error response and leaves reads open
  sequence prog_ok;
    PREADY && PWRITE && !PSLVERR && PADDR == `SBP_OFF_CMD && PWDATA[7:0] == `SBP_CMD_NV_PROG
      && $past(ARRAY_RD) && !ARRAY_RD_OK;
  endsequence
  sequence acc_start;
    PSEL && $rose(PENABLE);
  endsequence
  AST_READY_ONE_WAIT: assert property (acc_start |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  AST_READY_QUAL: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside an access phase");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_QUAL: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_RD_OK_CAUSE: assert property (ARRAY_RD_OK |-> $past(ARRAY_RD))
    else $error("read accepted without request");
  AST_WR_OK_CAUSE: assert property (ARRAY_WR_OK |-> $past(ARRAY_WR))
    else $error("write allowed without request");
  AST_RD_HELD_OFF: assert property (prog_ok |-> ##2 (!ARRAY_RD_OK) [*8])
    else $error("array read during guard program");
  AST_WR_HELD_OFF: assert property (prog_ok |-> ##2 (!ARRAY_WR_OK) [*8])
    else $error("array write while busy");
  AST_PROG_SPAN: assert property (prog_ok |-> ##[2:PROG_LIM] (ARRAY_RD_OK || !$past(ARRAY_RD)))
    else $error("guard program never completed");
endmodule
bind sbp_guard sbp_guard_chk #(.PROG_CYC(PROG_CYC)) u_chk (
  .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ARRAY_RD(ARRAY_RD), .ARRAY_WR(ARRAY_WR), .ARRAY_RD_OK(ARRAY_RD_OK),
  .ARRAY_WR_OK(ARRAY_WR_OK));

// file: dv/sbp_host.sv
// apb host model issuing guard commands
// assumes the bench calls xfer; waits are cut only by the bench watchdog
`timescale 1ns/10ps
module sbp_host (
  input wire logic CLOCK, // system clock
  output logic PSEL, // apb select
  output logic PENABLE, // apb access phase
  output logic PWRITE, // apb direction
  output logic [11:0] PADDR, // apb address
  output logic [31:0] PWDATA, // apb write data
  input wire logic [31:0] PRDATA, // apb read data
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR // apb error
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
  end
  // block base address, upper bits zero
  function automatic logic [31:0] blk_addr(input int b);
    return {6'h0, b[7:0], 18'h0};
  endfunction
  // one transfer; idle lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the block guard logic
// assumes the bound checker and the apb host model
`timescale 1ns/10ps
`include "sbp_map.svh"
module tb;
  logic clock = 1'b0, reset = 1'b1, hw_reset_n = 1'b1, arr_rd = 1'b0, arr_wr = 1'b0;
  logic [25:0] arr_addr = 26'h0;
  logic psel, penable, pwrite, pready, pslverr, rd_ok, wr_ok, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails = 0, compares = 0, b, c, nv[256], vol[256], freeze = 1, pw = 0;
  always #25 clock = ~clock;
  sbp_guard #(.PROG_CYC(20), .ERASE_CYC(40)) u_sbp_guard (.CLOCK(clock), .RESET(reset),
    .HW_RESET_N(hw_reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ARRAY_ADDR(arr_addr), .ARRAY_RD(arr_rd), .ARRAY_WR(arr_wr), .ARRAY_RD_OK(rd_ok),
    .ARRAY_WR_OK(wr_ok), .IRQ(irq));
  sbp_host u_sbp_host (.CLOCK(clock), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_sbp_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_sbp_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic cmd(input logic [7:0] code, input int blk, input logic v);
    wr(`SBP_OFF_ADDR, u_sbp_host.blk_addr(blk));
    wr(`SBP_OFF_CMD, {23'h0, v, code});
  endtask
  // poll busy under a bound; a hang shows up as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(`SBP_OFF_STATUS);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    chk(q[0], 0);
  endtask
  task automatic nvchk(input int blk);
    cmd(`SBP_CMD_NV_READ, blk, 1'b0);
    rd(`SBP_OFF_RDATA);
    chk(q[0], nv[blk]);
  endtask
  task automatic okchk(input int blk);
    wr(`SBP_OFF_ADDR, u_sbp_host.blk_addr(blk));
    rd(`SBP_OFF_BLOCK_OK);
    chk(q[0], nv[blk] & vol[blk]);
  endtask
  task automatic hwrst;
    hw_reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    hw_reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    freeze = !pw;
    foreach (vol[i]) vol[i] = 1;
  endtask
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    #1500000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hb876));
    foreach (nv[i]) begin
      nv[i] = 1;
      vol[i] = 1;
    end
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(`SBP_OFF_STATUS);
    chk(q[3:0], 32'h4);
    for (int i = 0; i < 3; i++) begin
      b = $urandom_range(255);
      nvchk(b);
      okchk(b);
    end
    wr(12'h020, 32'h0);
    chk(e, 1);
    wr(`SBP_OFF_CMD, 32'h0);
    chk(e, 1);
    $display("test reset done");
    wr(`SBP_OFF_IRQ_MASK, 32'h3);
    b = $urandom_range(253);
    c = b + 1;
    arr_addr <= 26'(u_sbp_host.blk_addr(b));
    arr_rd <= 1'b1;
    arr_wr <= 1'b1;
    cmd(`SBP_CMD_NV_PROG, b, 1'b0);
    nv[b] = 0;
    rd(`SBP_OFF_STATUS);
    chk(q[3], 1);
    chk(q[0], 1);
    chk(rd_ok, 0);
    wr(`SBP_OFF_CMD, 32'h3);
    chk(e, 1);
    wait_idle();
    rd(`SBP_OFF_IRQ_STAT);
    chk(q[1:0], 1);
    chk(irq, 1);
    wr(`SBP_OFF_IRQ_STAT, 32'h3);
    rd(`SBP_OFF_IRQ_STAT);
    chk(irq, 0);
    chk(wr_ok, 0);
    arr_addr <= 26'(u_sbp_host.blk_addr(c));
    repeat (2) @(posedge clock);
    chk(wr_ok, 1);
    chk(rd_ok, 1);
    nvchk(b);
    nvchk(c);
    cmd(`SBP_CMD_NV_PROG, 255, 1'b0);
    nv[255] = 0;
    wait_idle();
    nvchk(255);
    $display("test program done");
    for (int v = 0; v < 3; v++) begin
      cmd(`SBP_CMD_VOL_WRITE, c, v[0] ^ 1'b1);
      vol[c] = v[0] ^ 1;
      okchk(c);
    end
    cmd(`SBP_CMD_NV_ERASE, 0, 1'b0);
    foreach (nv[i]) nv[i] = 1;
    wait_idle();
    nvchk(b);
    nvchk(255);
    $display("test erase done");
    // freeze only after guard bits set
    cmd(`SBP_CMD_FREEZE, 0, 1'b0);
    freeze = 0;
    cmd(`SBP_CMD_NV_PROG, b, 1'b0);
    rd(`SBP_OFF_STATUS);
    chk(q[2:1], 32'h1);
    cmd(`SBP_CMD_UNLOCK, 0, 1'b0);
    rd(`SBP_OFF_STATUS);
    chk(q[2], freeze);
    nvchk(b);
    hwrst();
    rd(`SBP_OFF_STATUS);
    chk(q[2], freeze);
    okchk(c);
    wr(`SBP_OFF_MODE, 32'h1);
    pw = 1;
    hwrst();
    rd(`SBP_OFF_STATUS);
    chk(q[2], freeze);
    cmd(`SBP_CMD_UNLOCK, 0, 1'b0);
    rd(`SBP_OFF_STATUS);
    chk(q[2], 1);
    cmd(`SBP_CMD_VOL_WRITE, c, 1'b0);
    vol[c] = 0;
    okchk(c);
    cmd(`SBP_CMD_SOFT_RESET, 0, 1'b0);
    foreach (vol[i]) vol[i] = 1;
    okchk(c);
    $display("test freeze done");
    end_sim();
  end
endmodule

// file: verilog/sbp_guard.sv
// per-block write guard: non-volatile and volatile guard bits plus the freeze bit
// assumes an apb master on CLOCK; the hardware reset pin comes from outside and is synced
// Operation
// - one non-volatile bit per block, group erase
// - program drives 0, erase all to 1
// - array reads refused while programming
// - progress visible in status while busy
// - delivered state: all non-volatile bits 1
// - volatile write sets 0 or 1, repeatable
// - writable only when both bits 1
// - freeze 0 rejects program and erase
// - persistent mode: freeze 1 at reset, unsettable
// - password mode: freeze 0, unlock sets it
// - 256 KB blocks, indices 0 to 255
// - erase takes no address, no single erase
// - read returns addressed non-volatile bit
// - volatile bits unprotected after any reset
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
// offsets, command codes and timing counts
`include "sbp_map.svh"
module sbp_guard import sbp_pkg::*; #(
  parameter int NBLK = `SBP_NUM_BLOCKS,
  parameter int PROG_CYC = `SBP_PROG_CYC,
  parameter int ERASE_CYC = `SBP_ERASE_CYC
) (
  input wire logic CLOCK, // 20 MHz system clock
  input wire logic RESET, // synchronous reset, high (power-up)
  input wire logic HW_RESET_N, // hardware reset pin, low, asynchronous to CLOCK
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic [`SBP_ADDR_W-1:0] ARRAY_ADDR, // address of an array access
  input wire logic ARRAY_RD, // array read request
  input wire logic ARRAY_WR, // array program/erase request
  output logic ARRAY_RD_OK, // read accepted
  output logic ARRAY_WR_OK, // write allowed to addressed block
  output logic IRQ // level interrupt
);
  localparam int BW = $clog2(NBLK);
  localparam int TW = $clog2(ERASE_CYC + 1);
  // ******************************************
  // helpers
  // ******************************************
  // block index of a byte address
  // 256 KB blocks, index from address
  function automatic logic [BW-1:0] blk_of(input logic [`SBP_ADDR_W-1:0] a);
    blk_of = a[`SBP_BLOCK_LSB +: BW];
  endfunction
  // ******************************************
  // reset pin synchroniser
  // ******************************************
  logic hwr_meta; // first stage, read only by hwr_sync
  logic hwr_sync; // second stage, low while pin asserted
  logic hwr_prev; // delayed copy for edge detection
  logic hw_reset; // one-cycle pulse on pin assertion
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hwr_meta <= 1'b1;
      hwr_sync <= 1'b1;
      hwr_prev <= 1'b1;
    end else begin
      hwr_meta <= HW_RESET_N;
      hwr_sync <= hwr_meta;
      hwr_prev <= hwr_sync;
    end
  end
  assign hw_reset = hwr_prev & ~hwr_sync;
  // ******************************************
  // state
  // ******************************************
  sbp_state_t state, next_state; // engine state
  logic [NBLK-1:0] nv_bits, next_nv_bits; // non-volatile guard bits, 1 = open
  logic [NBLK-1:0] vol_bits, next_vol_bits; // volatile guard bits, 1 = open
  logic freeze, next_freeze; // guard_freeze_bit, 1 = changeable
  logic pw_mode, next_pw_mode; // 1 = password mode
  logic [BW-1:0] op_blk, next_op_blk; // block under program
  logic [`SBP_ADDR_W-1:0] addr_reg, next_addr_reg; // address register
  logic fail, next_fail; // last command failed
  logic rbit, next_rbit; // last read guard bit
  logic [`SBP_EV_W-1:0] irq_stat, next_irq_stat; // sticky events
  logic [`SBP_EV_W-1:0] irq_mask, next_irq_mask; // event enables
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq, next_rd_ok, next_wr_ok;
  logic tmr_load; // start the operation timer
  logic [TW-1:0] tmr_cycles; // its length
  logic tmr_done; // timer expired
  logic busy; // operation in progress
  assign busy = (state == SBP_PROG) || (state == SBP_ERASE);
  sbp_timer #(.W(TW)) u_timer (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .load(tmr_load),
    .cycles(tmr_cycles),
    .expire(tmr_done)
  );
  // ******************************************
  // next values
  // ******************************************
  // apb access, command engine, reset effects; one-cycle apb wait keeps outputs registered
  always_comb begin
    logic wr_acc, rd_acc;
    logic [`SBP_EV_W-1:0] ev;
    logic [7:0] cmd;
    wr_acc = PSEL & PENABLE & PWRITE & ~PREADY;
    rd_acc = PSEL & PENABLE & ~PWRITE & ~PREADY;
    ev = '0;
    cmd = PWDATA[7:0];
    next_state = state;
    next_nv_bits = nv_bits;
    next_vol_bits = vol_bits;
    next_freeze = freeze;
    next_pw_mode = pw_mode;
    next_op_blk = op_blk;
    next_addr_reg = addr_reg;
    next_fail = fail;
    next_rbit = rbit;
    next_irq_mask = irq_mask;
    next_prdata = PRDATA;
    next_pready = PSEL & PENABLE & ~PREADY;
    next_pslverr = 1'b0;
    tmr_load = 1'b0;
    tmr_cycles = '0;
    // engine progress
    case (state)
      SBP_IDLE: begin
      end
      SBP_PROG: begin
        if (tmr_done) begin
          next_nv_bits[op_blk] = 1'b0;
          next_state = SBP_DONE;
        end
      end
      SBP_ERASE: begin
        if (tmr_done) begin
          next_nv_bits = '1;
          next_state = SBP_DONE;
        end
      end
      SBP_DONE: begin
        ev[`SBP_EV_DONE] = 1'b1;
        next_state = SBP_IDLE;
      end
      default: next_state = SBP_IDLE;
    endcase
    if (wr_acc) begin
      case (PADDR)
        `SBP_OFF_ADDR: next_addr_reg = PWDATA[`SBP_ADDR_W-1:0];
        `SBP_OFF_MODE: next_pw_mode = PWDATA[0];
        `SBP_OFF_IRQ_MASK: next_irq_mask = PWDATA[`SBP_EV_W-1:0];
        `SBP_OFF_IRQ_STAT: begin
        end
        `SBP_OFF_CMD: begin
          if (busy) begin
            // commands during an operation are refused
            next_pslverr = 1'b1;
          end else begin
            next_fail = 1'b0;
            case (cmd)
              `SBP_CMD_NV_PROG, `SBP_CMD_NV_ERASE: begin
                if (!freeze) begin
                  next_fail = 1'b1;
                  ev[`SBP_EV_FAIL] = 1'b1;
                end else if (cmd == `SBP_CMD_NV_PROG) begin
                  next_op_blk = blk_of(addr_reg);
                  next_state = SBP_PROG;
                  tmr_load = 1'b1;
                  tmr_cycles = TW'(PROG_CYC);
                end else begin
                  next_state = SBP_ERASE;
                  tmr_load = 1'b1;
                  tmr_cycles = TW'(ERASE_CYC);
                end
              end
              `SBP_CMD_NV_READ: begin
                next_rbit = nv_bits[blk_of(addr_reg)];
              end
              `SBP_CMD_VOL_WRITE: begin
                // volatile bit takes 0 or 1
                next_vol_bits[blk_of(addr_reg)] = PWDATA[8];
              end
              `SBP_CMD_FREEZE: next_freeze = 1'b0;
              `SBP_CMD_UNLOCK: begin
                // only unlock sets freeze bit in password mode
                if (pw_mode) begin
                  next_freeze = 1'b1;
                end else begin
                  // no command sets it in persistent mode
                  next_fail = 1'b1;
                  ev[`SBP_EV_FAIL] = 1'b1;
                end
              end
              `SBP_CMD_SOFT_RESET: begin
                // volatile bits open after soft reset
                next_vol_bits = '1;
              end
              default: next_pslverr = 1'b1;
            endcase
          end
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    if (rd_acc) begin
      case (PADDR)
        `SBP_OFF_ADDR: next_prdata = 32'(addr_reg);
        `SBP_OFF_STATUS: next_prdata = 32'({busy & (state == SBP_PROG), freeze, fail, busy});
        `SBP_OFF_RDATA: next_prdata = {31'h0, rbit};
        `SBP_OFF_MODE: next_prdata = {31'h0, pw_mode};
        `SBP_OFF_IRQ_STAT: next_prdata = 32'(irq_stat);
        `SBP_OFF_IRQ_MASK: next_prdata = 32'(irq_mask);
        `SBP_OFF_BLOCK_OK: begin
          next_prdata = {31'h0, nv_bits[blk_of(addr_reg)] & vol_bits[blk_of(addr_reg)]};
        end
        `SBP_OFF_CMD: next_prdata = 32'h0;
        default: begin
          next_prdata = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // sticky events: set wins over write-one-to-clear
    next_irq_stat = irq_stat;
    if (wr_acc && PADDR == `SBP_OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~PWDATA[`SBP_EV_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
    // hardware reset pin: freeze to mode default, volatile bits open, operation aborted
    if (hw_reset) begin
      next_freeze = ~pw_mode;
      // volatile bits open after hardware reset
      next_vol_bits = '1;
      next_state = SBP_IDLE;
    end
    // no array reads during guard programming
    next_rd_ok = ARRAY_RD & (next_state != SBP_PROG) & (state != SBP_PROG);
    // writable only when both guard bits open
    next_wr_ok = ARRAY_WR & ~busy & (ARRAY_ADDR <= `SBP_TOP_ADDR)
               & nv_bits[blk_of(ARRAY_ADDR)] & vol_bits[blk_of(ARRAY_ADDR)];
  end
  // ******************************************
  // registers
  // ******************************************
  // power-up reset: mode defaults to persistent, so freeze starts at 1
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= SBP_IDLE;
      // delivered state all non-volatile bits open
      nv_bits <= '1;
      // volatile bits open after power cycle
      vol_bits <= '1;
      freeze <= 1'b1;
      pw_mode <= 1'b0;
      op_blk <= '0;
      addr_reg <= '0;
      fail <= 1'b0;
      rbit <= 1'b1;
      irq_stat <= '0;
      irq_mask <= '0;
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ <= 1'b0;
      ARRAY_RD_OK <= 1'b0;
      ARRAY_WR_OK <= 1'b0;
    end else begin
      state <= next_state;
      nv_bits <= next_nv_bits;
      vol_bits <= next_vol_bits;
      freeze <= next_freeze;
      pw_mode <= next_pw_mode;
      op_blk <= next_op_blk;
      addr_reg <= next_addr_reg;
      fail <= next_fail;
      rbit <= next_rbit;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      IRQ <= next_irq;
      ARRAY_RD_OK <= next_rd_ok;
      ARRAY_WR_OK <= next_wr_ok;
    end
  end
endmodule

// file: verilog/sbp_map.svh
// constants for the block guard logic: geometry, command codes, register offsets, timing
// assumes inclusion by the package and by the design modules
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
// geometry: 256 KB blocks of 4 KB sectors, top address 3ff_ffff
`define SBP_NUM_BLOCKS 256
`define SBP_BLOCK_LSB 18
`define SBP_ADDR_W 26
`define SBP_TOP_ADDR 26'h3ffffff
// apb register byte offsets
`define SBP_OFF_CMD 12'h000
`define SBP_OFF_ADDR 12'h004
`define SBP_OFF_STATUS 12'h008
`define SBP_OFF_RDATA 12'h00c
`define SBP_OFF_MODE 12'h010
`define SBP_OFF_IRQ_STAT 12'h014
`define SBP_OFF_IRQ_MASK 12'h018
`define SBP_OFF_BLOCK_OK 12'h01c
// command codes written to the command register
`define SBP_CMD_NV_PROG 8'h01
`define SBP_CMD_NV_ERASE 8'h02
`define SBP_CMD_NV_READ 8'h03
`define SBP_CMD_VOL_WRITE 8'h04
`define SBP_CMD_FREEZE 8'h05
`define SBP_CMD_UNLOCK 8'h06
`define SBP_CMD_SOFT_RESET 8'h07
// status bit positions
`define SBP_ST_BUSY 0
`define SBP_ST_FAIL 1
`define SBP_ST_FREEZE 2
`define SBP_ST_ARRAY_BLOCKED 3
// interrupt event bit positions
`define SBP_EV_DONE 0
`define SBP_EV_FAIL 1
`define SBP_EV_W 2
// operation times in microseconds at a 20 MHz clock
`define SBP_CLK_MHZ 20
`define SBP_PROG_US 400
`define SBP_ERASE_US 1000
`define SBP_PROG_CYC (`SBP_PROG_US * `SBP_CLK_MHZ)
`define SBP_ERASE_CYC (`SBP_ERASE_US * `SBP_CLK_MHZ)
`endif

// file: verilog/sbp_pkg.sv
// types for the block guard logic
// assumes sbp_map.svh beside it
`include "sbp_map.svh"
package sbp_pkg;
  // one-hot engine states
  typedef enum logic [3:0] {
    SBP_IDLE = 4'b0001,
    SBP_PROG = 4'b0010,
    SBP_ERASE = 4'b0100,
    SBP_DONE = 4'b1000
  } sbp_state_t;
endpackage

// file: verilog/sbp_timer.sv
// down counter that times a non-volatile guard operation
// assumes the same clock and synchronous reset as its parent
`timescale 1ns/10ps
module sbp_timer #(
  parameter int W = 16
) (
  input wire logic CLOCK, // system clock
  input wire logic RESET, // synchronous reset, high
  input wire logic load, // one-cycle start pulse
  input wire logic [W-1:0] cycles, // length of the wait
  output logic expire // one-cycle pulse at the end
);
  logic [W-1:0] count; // cycles left
  logic running; // count in progress
  logic [W-1:0] next_count;
  logic next_running;
  logic next_expire;
  // count down to one, then pulse
  always_comb begin
    next_count = count;
    next_running = running;
    next_expire = 1'b0;
    if (load) begin
      next_count = cycles;
      next_running = 1'b1;
    end else if (running) begin
      if (count <= {{(W-1){1'b0}}, 1'b1}) begin
        next_running = 1'b0;
        next_expire = 1'b1;
      end else begin
        next_count = count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  // register the counter
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      count <= '0;
      running <= 1'b0;
      expire <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      expire <= next_expire;
    end
  end
endmodule
